/* File: hw/ptc_counter.sv */
// one 8-bit up counter; clear wins over count
`timescale 1ns/100ps
module ptc_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control from the top
  ptc_cnt_if.unit cnt
);
  logic [7:0] count_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_q <= 8'h00;
    end else if (cnt.clr) begin
      count_q <= 8'h00;
    end else if (cnt.tick && cnt.run) begin
      count_q <= count_q + 8'h01;
    end
  end

  assign cnt.count = count_q;
  assign cnt.ovf = cnt.tick & cnt.run & (&count_q);
endmodule : ptc_counter

/* File: hw/ptc_prescaler.sv */
// prescaler producing one-cycle tap pulses at 1, 4, 16, 256 units
`timescale 1ns/100ps
module ptc_prescaler import ptc_pkg::*; #(
  parameter int unsigned TAP1_DIV = PRESCALE_BASE
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // tap pulses
  output logic [3:0] taps
);
  localparam int unsigned PRE_W = $clog2(TAP1_DIV) + 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TAP1_DIV - 1);

  logic [PRE_W-1:0] pre_q;
  logic [7:0] div_q;
  logic t1;

  assign t1 = (pre_q == PRE_LAST);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre_q <= '0;
    end else if (t1) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_q <= 8'h00;
    end else if (t1) begin
      div_q <= div_q + 8'h01;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_tap
    assign taps[i] = t1 & ((div_q & TAP_MASK[i]) == 8'h00);
  end
endmodule : ptc_prescaler

/* File: hw/ptc_top.sv */
// paired 8-bit timer with mode and compare registers
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/100ps
module ptc_top import ptc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt and waveform
  output logic irq,
  output logic pulse_out,
  // compare values handed to the lower pair
  output logic [7:0] lower_compare0,
  output logic [7:0] lower_compare1
);
  ptc_mode_e op;
  logic [1:0] pwm_sel;
  logic [1:0] dclk;
  logic [1:0] cclk;
  logic [7:0] mode_q;
  logic [1:0] run_q;
  logic [7:0] cmp_q [4];
  logic cmp_en_q;
  logic ack_q;
  logic pulse_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] stat_clr;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [3:0] taps;
  logic req;
  logic wr_fire;
  logic cmp_sel;
  logic [1:0] cmp_idx;
  logic [7:0] pwm_mask;
  logic [7:0] c_inc;
  logic [7:0] d_inc;
  logic [15:0] cnt16;
  logic c_src;
  logic d_src;
  logic c_go;
  logic d_go;
  logic c_hit;
  logic d_hit;
  logic ppg_end;
  logic pwm_end;
  logic hit16;

  ptc_cnt_if cif[2] ();

  for (genvar i = 0; i < 2; i++) begin : g_cnt
    ptc_counter u_cnt (
      .clk(clk),
      .rstn(rstn),
      .cnt(cif[i])
    );
  end

  ptc_prescaler u_pre (
    .clk(clk),
    .rstn(rstn),
    .taps(taps)
  );

  // bus: one wait state, read data sampled in the waiting cycle
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_fire = avs_write & ack_q & avs_byteenable[0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_comb begin
    cmp_sel = 1'b0;
    cmp_idx = SEL_00;
    for (int i = 0; i < 4; i++) begin
      if (avs_address == (CMP_IDX[i] << 2)) begin
        cmp_sel = 1'b1;
        cmp_idx = 2'(i);
      end
    end
  end

  // compare registers ignore reads: nothing to read back, they return zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (avs_address)
      IDX_MODE << 2: rdata_d[7:0] = mode_q;
      IDX_RUN << 2: rdata_d[1:0] = run_q;
      IDX_COUNT << 2: rdata_d[15:0] = {cif[1].count, cif[0].count};
      IDX_IRQ_STAT << 2: rdata_d[IRQ_W-1:0] = stat_q;
      IDX_IRQ_MASK << 2: rdata_d[IRQ_W-1:0] = mask_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_q <= MODE_RST;
    end else if (wr_fire && avs_address == (IDX_MODE << 2)) begin
      mode_q <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      run_q <= SEL_00;
    end else if (wr_fire && avs_address == (IDX_RUN << 2)) begin
      run_q <= avs_writedata[1:0];
    end
  end

  // contents are undefined to software; zero keeps sim clean
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int k = 0; k < 4; k++) begin
        cmp_q[k] <= 8'h00;
      end
    end else if (wr_fire && cmp_sel) begin
      cmp_q[cmp_idx] <= avs_writedata[7:0];
    end
  end

  assign lower_compare0 = cmp_q[0];
  assign lower_compare1 = cmp_q[1];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmp_en_q <= 1'b1;
    end else if (wr_fire && cmp_sel && op == PTC_CASC16) begin
      if (cmp_idx == SEL_10) begin
        cmp_en_q <= 1'b0;
      end else if (cmp_idx == SEL_11) begin
        cmp_en_q <= 1'b1;
      end
    end
  end

  // mode decode
  assign op = ptc_mode_e'(mode_q[MODE_OP_LSB +: 2]);
  assign pwm_sel = mode_q[MODE_PWM_LSB +: 2];
  assign dclk = mode_q[MODE_DCLK_LSB +: 2];
  assign cclk = mode_q[MODE_CCLK_LSB +: 2];

  always_comb begin
    case (cclk)
      SEL_01: c_src = taps[TAP_1];
      SEL_10: c_src = taps[TAP_4];
      SEL_11: c_src = taps[TAP_16];
      default: c_src = 1'b0;
    endcase
  end

  always_comb begin
    case (pwm_sel)
      SEL_01: pwm_mask = PWM_MASK_6;
      SEL_10: pwm_mask = PWM_MASK_7;
      SEL_11: pwm_mask = PWM_MASK_8;
      default: pwm_mask = 8'h00;
    endcase
  end

  // reserved pwm period freezes the lower timer
  assign cif[0].tick = c_src &
    !(op == PTC_PWM && pwm_sel == SEL_00);
  assign cif[0].run = run_q[RUN_C_BIT];
  assign cif[1].run = run_q[RUN_D_BIT];

  assign c_go = cif[0].tick & run_q[RUN_C_BIT];
  assign c_inc = cif[0].count + 8'h01;
  assign c_hit = c_go & (c_inc == cmp_q[2]);
  assign ppg_end = c_go & (c_inc == cmp_q[3]);
  assign pwm_end = c_go & ((c_inc & pwm_mask) == 8'h00);

  always_comb begin
    case (dclk)
      SEL_01: d_src = taps[TAP_1];
      SEL_10: d_src = taps[TAP_16];
      SEL_11: d_src = taps[TAP_256];
      default: d_src = c_hit;
    endcase
  end

  // the upper counter's mux has no feedback path from itself
  always_comb begin
    case (op)
      PTC_CASC16: cif[1].tick = cif[0].ovf;
      PTC_PPG: cif[1].tick = 1'b0;
      default: cif[1].tick = d_src;
    endcase
  end

  assign d_go = cif[1].tick & run_q[RUN_D_BIT];
  assign d_inc = cif[1].count + 8'h01;
  assign d_hit = d_go & (d_inc == cmp_q[3]);
  assign cnt16 = {cif[1].count, cif[0].count} + 16'h0001;
  assign hit16 = c_go & cmp_en_q &
    (cnt16 == {cmp_q[3], cmp_q[2]});

  // a stopped counter is held at zero
  always_comb begin
    case (op)
      PTC_DUAL8: begin
        cif[0].clr = !run_q[RUN_C_BIT] | c_hit;
        cif[1].clr = !run_q[RUN_D_BIT] | d_hit;
      end
      PTC_CASC16: begin
        cif[0].clr = !run_q[RUN_C_BIT] | hit16;
        cif[1].clr = !run_q[RUN_D_BIT] | hit16;
      end
      PTC_PPG: begin
        cif[0].clr = !run_q[RUN_C_BIT] | ppg_end;
        cif[1].clr = 1'b1;
      end
      default: begin
        cif[0].clr = !run_q[RUN_C_BIT] | pwm_end;
        cif[1].clr = !run_q[RUN_D_BIT] | d_hit;
      end
    endcase
  end

  // interrupt events
  assign events[IRQ_C_MATCH] = c_hit & (op != PTC_CASC16);
  assign events[IRQ_D_MATCH] = (op == PTC_CASC16) ? hit16 : d_hit;
  assign events[IRQ_PWM_END] = pwm_end & (op == PTC_PWM);
  assign stat_clr = (wr_fire && avs_address == (IDX_IRQ_STAT << 2)) ?
    avs_writedata[IRQ_W-1:0] : '0;

  // set beats a simultaneous write-one-to-clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | events;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_q <= '0;
    end else if (wr_fire && avs_address == (IDX_IRQ_MASK << 2)) begin
      mask_q <= avs_writedata[IRQ_W-1:0];
    end
  end

  assign irq = |(stat_q & mask_q);

  // waveform: ppg toggles at both compares, pwm sets at period start
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pulse_q <= 1'b0;
    end else begin
      case (op)
        PTC_PPG: begin
          if (c_hit || ppg_end) begin
            pulse_q <= ~pulse_q;
          end
        end
        PTC_PWM: begin
          if (pwm_end) begin
            pulse_q <= 1'b1;
          end else if (c_hit) begin
            pulse_q <= 1'b0;
          end
        end
        default: begin
          if (events[IRQ_D_MATCH]) begin
            pulse_q <= ~pulse_q;
          end
        end
      endcase
    end
  end

  assign pulse_out = pulse_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_MODE_RESET: assert property (
    disable iff (1'b0) !rstn |=> mode_q == 8'h00 && op == PTC_DUAL8)
    else $error("mode register not zero after reset");

  AST_PPG_UPPER_IDLE: assert property (
    op == PTC_PPG |=> cif[1].count == 8'h00)
    else $error("upper timer counts in pulse mode");

  AST_PWM_UPPER_TIMER: assert property (
    op == PTC_PWM && d_hit |=> stat_q[IRQ_D_MATCH] &&
    cif[1].count == 8'h00)
    else $error("upper timer not plain in pwm mode");

  AST_PWM_PERIOD: assert property (
    op == PTC_PWM && pwm_sel == SEL_01 && pwm_end |->
    cif[0].count[5:0] == 6'h3F ##1 cif[0].count == 8'h00)
    else $error("pwm period wrong");

  AST_UPPER_CLOCK: assert property (
    op == PTC_DUAL8 && dclk == SEL_11 |->
    cif[1].tick == taps[TAP_256])
    else $error("upper clock select wrong");

  AST_LOWER_CLOCK: assert property (
    cclk == SEL_10 && op != PTC_PWM |-> cif[0].tick == taps[TAP_4])
    else $error("lower clock select wrong");

  AST_COMPARE_WRITE: assert property (
    wr_fire && avs_address == (CMP_IDX[3] << 2) |=>
    cmp_q[3] == $past(avs_writedata[7:0]))
    else $error("compare register write lost");

  AST_COMPARE_NO_READ: assert property (
    avs_read && !ack_q && cmp_sel |=> avs_readdata == 32'h0000_0000)
    else $error("compare register read back nonzero");

  AST_DUAL_INDEPENDENT: assert property (
    op == PTC_DUAL8 && c_hit && !cif[1].tick |=>
    cif[0].count == 8'h00 && $stable(cif[1].count))
    else $error("dual timers not independent");

  AST_CASCADE_CLOCK: assert property (
    op == PTC_CASC16 |-> cif[1].tick == cif[0].ovf)
    else $error("upper not clocked by overflow");

  AST_CASCADE_SUSPEND: assert property (
    op == PTC_CASC16 && wr_fire && avs_address == (CMP_IDX[2] << 2)
    |=> !cmp_en_q ##0 !hit16)
    else $error("low compare write did not suspend");

  AST_RESERVED_IDLE: assert property (
    cclk == SEL_00 && run_q[RUN_C_BIT] |=> $stable(cif[0].count))
    else $error("counter advanced on reserved clock");

endmodule : ptc_top

/* File: include/ptc_cnt_if.sv */
// control and status bundle between the top and one 8-bit counter
`timescale 1ns/100ps
interface ptc_cnt_if;
  logic tick;
  logic run;
  logic clr;
  logic [7:0] count;
  logic ovf;
  modport ctl (output tick, output run, output clr,
               input count, input ovf);
  modport unit (input tick, input run, input clr,
                output count, output ovf);
endinterface : ptc_cnt_if

/* File: include/ptc_pkg.sv */
// shared constants and types for the paired 8-bit timer block
package ptc_pkg;

  // register indices; byte address is the index times four
  localparam logic [15:0] IDX_RUN = 16'h1100;
  localparam logic [15:0] IDX_COUNT = 16'h1101;
  localparam logic [15:0] IDX_MODE = 16'h110C;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h1110;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h1111;
  localparam logic [15:0] CMP_IDX [4] = '{
    16'h1102, 16'h1103, 16'h110A, 16'h110B
  };

  // upper_pair_mode field positions and reset value
  localparam int unsigned MODE_OP_LSB = 6;
  localparam int unsigned MODE_PWM_LSB = 4;
  localparam int unsigned MODE_DCLK_LSB = 2;
  localparam int unsigned MODE_CCLK_LSB = 0;
  localparam logic [7:0] MODE_RST = 8'h00;

  // run register bits
  localparam int unsigned RUN_C_BIT = 0;
  localparam int unsigned RUN_D_BIT = 1;

  // interrupt status bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_C_MATCH = 0;
  localparam int unsigned IRQ_D_MATCH = 1;
  localparam int unsigned IRQ_PWM_END = 2;

  // two-bit select codes
  localparam logic [1:0] SEL_00 = 2'b00;
  localparam logic [1:0] SEL_01 = 2'b01;
  localparam logic [1:0] SEL_10 = 2'b10;
  localparam logic [1:0] SEL_11 = 2'b11;

  // pwm period masks for 2^6, 2^7, 2^8 source clocks
  localparam logic [7:0] PWM_MASK_6 = 8'h3F;
  localparam logic [7:0] PWM_MASK_7 = 8'h7F;
  localparam logic [7:0] PWM_MASK_8 = 8'hFF;

  // prescaler: tap_1 period in system clocks, tap masks
  localparam int unsigned PRESCALE_BASE = 8;
  localparam int unsigned TAP_1 = 0;
  localparam int unsigned TAP_4 = 1;
  localparam int unsigned TAP_16 = 2;
  localparam int unsigned TAP_256 = 3;
  localparam logic [7:0] TAP_MASK [4] = '{
    8'h00, 8'h03, 8'h0F, 8'hFF
  };

  typedef enum logic [1:0] {
    PTC_DUAL8,
    PTC_CASC16,
    PTC_PPG,
    PTC_PWM
  } ptc_mode_e;

endpackage : ptc_pkg

/* File: sim/ptc_top_bench.sv */
// self-checking bench for the paired 8-bit timer top
`timescale 1ns/100ps
module ptc_top_bench import ptc_pkg::*; ();
  logic clk;
  logic rstn;
  logic [15:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic pulse_out;
  logic [7:0] lower_compare0;
  logic [7:0] lower_compare1;
  int failures;
  int checks_done;
  int cyc = 0;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [7:0] n;
  logic keep;
  logic [7:0] modes [6] = '{8'h05, 8'h09, 8'h0D, 8'h01, 8'h02, 8'h03};
  int mults [6] = '{1, 16, 256, 3, 12, 48};

  ptc_top dut (
    .clk(clk),
    .rstn(rstn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq(irq),
    .pulse_out(pulse_out),
    .lower_compare0(lower_compare0),
    .lower_compare1(lower_compare1)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one avalon transfer; request held until waitrequest sampled low
  task automatic bus(input logic wr, input logic [15:0] idx,
                     input logic [7:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= {idx[13:0], 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask : wr

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00, 4'hF);
    check(rd, exp);
  endtask : rdc

  // cycles between two successive pulse edges (rise only, or any)
  task automatic gap(input bit rise, input int exp);
    int t [2];
    int j;
    int k;
    logic p;
    for (j = 0; j < 2; j++) begin
      p = pulse_out;
      for (k = 0; k < 20000; k++) begin
        @(posedge clk);
        if (pulse_out !== p && (!rise || pulse_out === 1'b1)) break;
        p = pulse_out;
      end
      t[j] = cyc;
    end
    check(t[1] - t[0], exp);
  endtask : gap

  task automatic wrap_up();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // watchdog sized well above the longest expected run
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial begin
    rstn = 1'b0;
    avs_address = 16'h0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    failures = 0;
    checks_done = 0;
    seed = 32'd67260;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(IDX_MODE, 32'h0000_0000);
    check(irq, 1'b0);
    for (int i = 0; i < 4; i++) rdc(CMP_IDX[i], 32'h0000_0000);
    rdc(16'h1200, 32'h0000_0000);
    // no external count pin here, so no port setup precedes mode
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr(IDX_MODE, seed[7:0]);
      rdc(IDX_MODE, {24'h00_0000, seed[7:0]});
    end
    // byteenable 0 must leave the register alone
    bus(1'b1, IDX_MODE, ~seed[7:0], 4'h0);
    rdc(IDX_MODE, {24'h00_0000, seed[7:0]});
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      wr(CMP_IDX[i], seed[7:0]);
      @(posedge clk);
      check(i ? lower_compare1 : lower_compare0, seed[7:0]);
    end
    // reserved lower clock, reserved pwm period: counter stays idle
    for (int i = 0; i < 2; i++) begin
      wr(IDX_RUN, 8'h00);
      wr(IDX_MODE, i ? 8'hC1 : 8'h00);
      wr(IDX_RUN, 8'h01);
      repeat (200) @(posedge clk);
      rdc(IDX_COUNT, 32'h0000_0000);
    end
    seed = lfsr(seed);
    n = 8'h02 + {6'h00, seed[1:0]};
    wr(CMP_IDX[2], 8'h03);
    wr(CMP_IDX[3], n);
    for (int i = 0; i < 6; i++) begin
      wr(IDX_RUN, 8'h00);
      wr(IDX_MODE, modes[i]);
      wr(IDX_RUN, 8'h03);
      gap(1'b0, n * PRESCALE_BASE * mults[i]);
    end
    wr(IDX_RUN, 8'h00);
    rdc(IDX_IRQ_STAT, 32'h0000_0003);
    check(irq, 1'b0);
    wr(IDX_IRQ_MASK, 8'h02);
    @(posedge clk);
    check(irq, 1'b1);
    wr(IDX_IRQ_STAT, 8'h02);
    @(posedge clk);
    check(irq, 1'b0);
    rdc(IDX_IRQ_STAT, 32'h0000_0001);
    wr(IDX_IRQ_STAT, 8'h07);
    wr(CMP_IDX[2], 8'h10);
    for (int p = 1; p < 4; p++) begin
      wr(IDX_RUN, 8'h00);
      wr(IDX_MODE, {2'b11, p[1:0], 2'b01, 2'b01});
      wr(IDX_RUN, 8'h03);
      gap(1'b1, (1 << (5 + p)) * PRESCALE_BASE);
    end
    wr(IDX_RUN, 8'h00);
    bus(1'b0, IDX_IRQ_STAT, 8'h00, 4'hF);
    check(rd[IRQ_PWM_END], 1'b1);
    check(rd[IRQ_D_MATCH], 1'b1);
    // cascade with upper select at tap_256, which must be ignored
    wr(IDX_MODE, 8'h4D);
    wr(CMP_IDX[2], 8'h10);
    wr(CMP_IDX[3], 8'h01);
    wr(IDX_RUN, 8'h03);
    gap(1'b0, 16'h0110 * PRESCALE_BASE);
    wr(CMP_IDX[2], 8'h10);
    keep = pulse_out;
    repeat (5000) @(posedge clk);
    check(pulse_out, keep);
    // counter ran past the match while suspended: restart from zero
    wr(IDX_RUN, 8'h00);
    wr(CMP_IDX[3], 8'h01);
    wr(IDX_RUN, 8'h03);
    gap(1'b0, 16'h0110 * PRESCALE_BASE);
    // pulse mode: period from timer3_compare, upper timer held idle
    wr(IDX_RUN, 8'h00);
    wr(IDX_MODE, 8'h81);
    wr(CMP_IDX[2], 8'h03);
    wr(CMP_IDX[3], 8'h08);
    wr(IDX_RUN, 8'h03);
    gap(1'b1, 8 * PRESCALE_BASE);
    bus(1'b0, IDX_COUNT, 8'h00, 4'hF);
    check(rd[15:8], 8'h00);
    wr(IDX_RUN, 8'h00);
    wrap_up();
  end
endmodule : ptc_top_bench
